// ==== verilog/fcs_pkg.sv ====
// Constants, register map and mode encoding for the clock source unit.
// Assumes a single 10 MHz system clock; every derived clock is an enable pulse.

package fcs_pkg;

	// -------------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// -------------------------------------------------------------------
	localparam logic [11:0] CTRL1_ADDR  = 12'h000;
	localparam logic [11:0] CTRL2_ADDR  = 12'h004;
	localparam logic [11:0] TRIM_ADDR   = 12'h008;
	localparam logic [11:0] STATUS_ADDR = 12'h00C;

	// -------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------
	localparam int SRC_SEL_LSB     = 6;
	localparam int REF_DIV_LSB     = 3;
	localparam int INT_REF_SEL_BIT = 2;
	localparam int IRCLKEN_BIT     = 1;
	localparam int IRSTEN_BIT      = 0;
	localparam int BUS_DIV_LSB     = 6;
	localparam int RANGE_BIT       = 5;
	localparam int HIGH_GAIN_BIT   = 4;
	localparam int LOW_POWER_BIT   = 3;
	localparam int OSC_SEL_BIT     = 2;
	localparam int EXT_CLK_EN_BIT  = 1;
	localparam int ERSTEN_BIT  = 0;
	localparam int FLLEN_BIT   = 7;
	localparam int IRON_BIT    = 8;
	localparam int ERON_BIT    = 9;
	localparam int SRC_LSB     = 10;

	// -------------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------------
	localparam logic [7:0] CTRL1_RESET = 8'h04;
	localparam logic [7:0] CTRL2_RESET = 8'h40;
	localparam logic [8:0] TRIM_RESET  = 9'h100;

	// -------------------------------------------------------------------
	// Clock source selections
	// -------------------------------------------------------------------
	localparam logic [1:0] SRC_FLL = 2'h0;
	localparam logic [1:0] SRC_INT = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;

	// -------------------------------------------------------------------
	// Timing of the behavioural loop model
	// -------------------------------------------------------------------
	localparam int CLOCK_HZ           = 10_000_000;
	localparam int INT_REF_HZ         = 32_768;
	localparam logic [15:0] INT_REF_BASE = 16'(CLOCK_HZ / INT_REF_HZ - 256);
	localparam logic [15:0] FLL_FACTOR   = 16'h0008;
	localparam logic [15:0] DCO_RESET    = 16'h0020;

	typedef enum logic [6:0] {
		FCS_ENG_INT     = 7'h01,
		FCS_ENG_EXT     = 7'h02,
		FCS_BYP_INT     = 7'h04,
		FCS_BYP_INT_LOW = 7'h08,
		FCS_BYP_EXT     = 7'h10,
		FCS_BYP_EXT_LOW = 7'h20,
		FCS_STOP        = 7'h40
	} fcs_mode_t;

endpackage

// ==== verilog/fcs_clock_source.sv ====
// Clock source unit: loop model, source selection, bus and debug dividers, APB registers.
// Assumes an on-chip APB master; all clocks leave as one-cycle enables on clock.
`timescale 1ns/10ps

// Operation
// - Reset lands in loop-engaged internal mode.
// - Engaged internal: loop output, internal reference.
// - Engaged external: loop output, external reference.
// - Bypassed internal: loop on, internal clock out.
// - Bypassed internal lowpower: loop off, no debug.
// - Bypassed external: loop on, external clock out.
// - Bypassed external lowpower: loop off, no debug.
// - Stop: loop off, no clocks, references optional.
// - Bus divider select divides 1,2,4,8.
// - Bus clock is half the output clock.
// - Debug clock is loop oscillator divided two.
// - Reference divider selected by three bits.
// - Internal reference trimmed by nine bits.
// - Drive the external oscillator control signals.
// - All ports stay on chip.
// - Source select: loop, internal, external, reserved.
// - Bus divider resets to divide by two.
// - Reference divider 1 to 128, resets 000.
// - Low power bypass disables loop unless debugging.
module fcs_clock_source
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        stop_request,
	input  wire logic        bdm_active,
	input  wire logic        ext_ref_tick,
	output logic             clock_source_output,
	output logic             bus_clock_en,
	output logic             background_debug_clock,
	output logic             fll_enabled,
	output logic             int_ref_clock_active,
	output logic             ext_ref_clock_enable,
	output logic             ext_ref_stop_enable,
	output logic             ext_ref_oscillator_select,
	output logic             high_gain_select,
	output logic             range_select,
	output logic [6:0]       mode_state
);

	// -------------------------------------------------------------------
	// Register state
	// -------------------------------------------------------------------
	logic [7:0]               ctrl1_reg;
	logic [7:0]               ctrl2_reg;
	logic [8:0]               trim_reg;
	fcs_pkg::fcs_mode_t       mode_reg;
	fcs_pkg::fcs_mode_t       mode_next;
	logic [1:0]               src_sel;
	logic [2:0]               ref_div;
	logic [1:0]               bus_div;
	logic                     int_ref_sel;
	logic                     low_power;
	logic                     fll_on;
	logic                     ir_on;
	logic                     er_on;
	logic                     wr_en;
	logic                     rd_en;

	assign src_sel     = ctrl1_reg[fcs_pkg::SRC_SEL_LSB +: 2];
	assign ref_div     = ctrl1_reg[fcs_pkg::REF_DIV_LSB +: 3];
	assign int_ref_sel = ctrl1_reg[fcs_pkg::INT_REF_SEL_BIT];
	assign bus_div     = ctrl2_reg[fcs_pkg::BUS_DIV_LSB +: 2];
	assign low_power   = ctrl2_reg[fcs_pkg::LOW_POWER_BIT];
	assign wr_en = psel && penable && pwrite && !pready;
	assign rd_en = psel && penable && !pwrite && !pready;

	// Reports whether an address hits one of the four words.
	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == fcs_pkg::CTRL1_ADDR) || (a == fcs_pkg::CTRL2_ADDR)
			|| (a == fcs_pkg::TRIM_ADDR) || (a == fcs_pkg::STATUS_ADDR);
	endfunction

	// Operating mode from the configuration bits and the stop request.
	function automatic fcs_pkg::fcs_mode_t decode_mode(input logic [1:0] src,
		input logic ref_int, input logic low_pwr, input logic dbg, input logic stp);
		logic lpm;
		lpm = low_pwr && !dbg;
		if (stp)
			decode_mode = fcs_pkg::FCS_STOP;
		else if (src == fcs_pkg::SRC_INT)
			decode_mode = lpm ? fcs_pkg::FCS_BYP_INT_LOW : fcs_pkg::FCS_BYP_INT;
		else if (src == fcs_pkg::SRC_EXT)
			decode_mode = lpm ? fcs_pkg::FCS_BYP_EXT_LOW : fcs_pkg::FCS_BYP_EXT;
		else
			decode_mode = ref_int ? fcs_pkg::FCS_ENG_INT : fcs_pkg::FCS_ENG_EXT;
	endfunction

	assign mode_next = decode_mode(src_sel, int_ref_sel, low_power, bdm_active, stop_request);

	// -------------------------------------------------------------------
	// APB register writes
	// -------------------------------------------------------------------
	// A reserved source code is stored as the loop selection.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ctrl1_reg <= fcs_pkg::CTRL1_RESET;
			ctrl2_reg <= fcs_pkg::CTRL2_RESET;
			trim_reg  <= fcs_pkg::TRIM_RESET;
		end
		else if (wr_en)
		begin
			if (paddr == fcs_pkg::CTRL1_ADDR)
			begin
				ctrl1_reg <= pwdata[7:0];
				if (pwdata[7:6] == 2'h3)
					ctrl1_reg[fcs_pkg::SRC_SEL_LSB +: 2] <= fcs_pkg::SRC_FLL;
			end
			if (paddr == fcs_pkg::CTRL2_ADDR)
				ctrl2_reg <= pwdata[7:0];
			if (paddr == fcs_pkg::TRIM_ADDR)
				trim_reg <= pwdata[8:0];
		end
	end

	// -------------------------------------------------------------------
	// APB answer: one wait state, registered data and error
	// -------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_hit(paddr);
			prdata  <= 32'h0000_0000;
			if (rd_en)
			begin
				unique case (paddr)
					fcs_pkg::CTRL1_ADDR:  prdata <= {24'h00_0000, ctrl1_reg};
					fcs_pkg::CTRL2_ADDR:  prdata <= {24'h00_0000, ctrl2_reg};
					fcs_pkg::TRIM_ADDR:   prdata <= {23'h00_0000, trim_reg};
					fcs_pkg::STATUS_ADDR: prdata <= {20'h0_0000, src_sel, er_on, ir_on,
						fll_on, mode_reg};
					default:              prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// -------------------------------------------------------------------
	// Mode and enables of loop and references
	// -------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			mode_reg <= fcs_pkg::FCS_ENG_INT;
		else
			mode_reg <= mode_next;
	end

	// The loop runs in every mode except the low power bypasses and stop.
	assign fll_on = mode_reg inside {fcs_pkg::FCS_ENG_INT, fcs_pkg::FCS_ENG_EXT,
		fcs_pkg::FCS_BYP_INT, fcs_pkg::FCS_BYP_EXT};

	logic ir_used_reg;
	logic er_used_reg;

	// Which reference was in use is latched while running, so stop can keep it.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ir_used_reg <= 1'b1;
			er_used_reg <= 1'b0;
		end
		else if (mode_reg != fcs_pkg::FCS_STOP)
		begin
			ir_used_reg <= mode_reg inside {fcs_pkg::FCS_ENG_INT, fcs_pkg::FCS_BYP_INT,
				fcs_pkg::FCS_BYP_INT_LOW};
			er_used_reg <= mode_reg inside {fcs_pkg::FCS_ENG_EXT, fcs_pkg::FCS_BYP_EXT,
				fcs_pkg::FCS_BYP_EXT_LOW};
		end
	end

	assign ir_on = (mode_reg != fcs_pkg::FCS_STOP) || (ctrl1_reg[fcs_pkg::IRSTEN_BIT]
		&& (ctrl1_reg[fcs_pkg::IRCLKEN_BIT] || ir_used_reg));
	assign er_on = (mode_reg != fcs_pkg::FCS_STOP) ? (ctrl2_reg[fcs_pkg::EXT_CLK_EN_BIT]
		|| er_used_reg) : (ctrl2_reg[fcs_pkg::ERSTEN_BIT]
		&& (ctrl2_reg[fcs_pkg::EXT_CLK_EN_BIT] || er_used_reg));

	// -------------------------------------------------------------------
	// Internal reference with nine-bit trim
	// -------------------------------------------------------------------
	logic [15:0] ir_cnt_reg;
	logic        ir_tick;
	logic        er_tick;

	assign ir_tick = ir_on && (ir_cnt_reg == 16'h0000);
	assign er_tick = er_on && ext_ref_tick;

	// A larger trim value lengthens the period and so lowers the frequency.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ir_cnt_reg <= 16'h0000;
		else if (!ir_on)
			ir_cnt_reg <= 16'h0000;
		else if (ir_tick)
			ir_cnt_reg <= fcs_pkg::INT_REF_BASE + {7'h00, trim_reg};
		else
			ir_cnt_reg <= ir_cnt_reg - 16'h0001;
	end

	// -------------------------------------------------------------------
	// Reference divider and frequency-locked loop
	// -------------------------------------------------------------------
	logic [6:0]  ref_div_cnt_reg;
	logic        fll_ref_tick;
	logic        ref_tick;
	logic [15:0] dco_cnt_reg;
	logic [15:0] dco_period_reg;
	logic [15:0] dco_seen_reg;
	logic        dco_tick;

	assign ref_tick     = int_ref_sel ? ir_tick : er_tick;
	assign fll_ref_tick = fll_on && ref_tick
		&& (ref_div_cnt_reg == 7'(({7'h00, 1'b1} << ref_div) - 8'h01));

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ref_div_cnt_reg <= 7'h00;
		else if (!fll_on)
			ref_div_cnt_reg <= 7'h00;
		else if (fll_ref_tick)
			ref_div_cnt_reg <= 7'h00;
		else if (ref_tick)
			ref_div_cnt_reg <= ref_div_cnt_reg + 7'h01;
	end

	assign dco_tick = fll_on && (dco_cnt_reg == 16'h0000);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			dco_cnt_reg <= 16'h0000;
		else if (!fll_on || dco_tick)
			dco_cnt_reg <= dco_period_reg;
		else
			dco_cnt_reg <= dco_cnt_reg - 16'h0001;
	end

	// Each divided reference period the oscillator count is compared with the
	// target and the period nudged by one, a slow but monotonic lock.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			dco_period_reg <= fcs_pkg::DCO_RESET;
			dco_seen_reg   <= 16'h0000;
		end
		else if (!fll_on)
			dco_seen_reg <= 16'h0000;
		else if (fll_ref_tick)
		begin
			dco_seen_reg <= 16'h0000;
			if (dco_seen_reg > fcs_pkg::FLL_FACTOR)
				dco_period_reg <= dco_period_reg + 16'h0001;
			else if (dco_seen_reg < fcs_pkg::FLL_FACTOR && dco_period_reg != 16'h0000)
				dco_period_reg <= dco_period_reg - 16'h0001;
		end
		else if (dco_tick && dco_seen_reg != 16'hFFFF)
			dco_seen_reg <= dco_seen_reg + 16'h0001;
	end

	// -------------------------------------------------------------------
	// Debug clock: constant halving of the oscillator
	// -------------------------------------------------------------------
	logic dbg_phase_reg;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			dbg_phase_reg          <= 1'b0;
			background_debug_clock <= 1'b0;
		end
		else
		begin
			if (dco_tick)
				dbg_phase_reg <= !dbg_phase_reg;
			background_debug_clock <= dco_tick && dbg_phase_reg;
		end
	end

	// -------------------------------------------------------------------
	// Source selection, bus divider and bus clock
	// -------------------------------------------------------------------
	logic [1:0] src_reg;
	logic       src_tick;
	logic [6:0] bus_div_cnt_reg;
	logic       out_tick;
	logic       bus_phase_reg;
	logic [1:0] want_src;

	assign want_src = (src_sel == 2'h3) ? fcs_pkg::SRC_FLL : src_sel;

	always_comb
	begin
		unique case (src_reg)
			fcs_pkg::SRC_INT: src_tick = ir_tick;
			fcs_pkg::SRC_EXT: src_tick = er_tick;
			default:          src_tick = dco_tick;
		endcase
	end

	assign out_tick = (mode_reg != fcs_pkg::FCS_STOP) && src_tick
		&& (bus_div_cnt_reg == 7'(({7'h00, 1'b1} << bus_div) - 8'h01));

	// The source changes at an output tick or in any cycle where the divider count is zero
	// and the current source gives no tick, so the count is always zero when it changes.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			src_reg         <= fcs_pkg::SRC_FLL;
			bus_div_cnt_reg <= 7'h00;
		end
		else if (out_tick || bus_div_cnt_reg == 7'h00 && !src_tick)
		begin
			src_reg         <= want_src;
			bus_div_cnt_reg <= 7'h00;
		end
		else if (src_tick)
			bus_div_cnt_reg <= bus_div_cnt_reg + 7'h01;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			clock_source_output <= 1'b0;
			bus_clock_en        <= 1'b0;
			bus_phase_reg       <= 1'b0;
		end
		else
		begin
			clock_source_output <= out_tick;
			if (out_tick)
				bus_phase_reg <= !bus_phase_reg;
			bus_clock_en <= out_tick && bus_phase_reg;
		end
	end

	// -------------------------------------------------------------------
	// Status and oscillator control outputs, on-chip only
	// -------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			fll_enabled               <= 1'b1;
			int_ref_clock_active      <= 1'b0;
			ext_ref_clock_enable      <= 1'b0;
			ext_ref_stop_enable       <= 1'b0;
			ext_ref_oscillator_select <= 1'b0;
			high_gain_select          <= 1'b0;
			range_select              <= 1'b0;
			mode_state                <= fcs_pkg::FCS_ENG_INT;
		end
		else
		begin
			fll_enabled               <= fll_on;
			int_ref_clock_active      <= ir_on && ctrl1_reg[fcs_pkg::IRCLKEN_BIT];
			ext_ref_clock_enable      <= er_on;
			ext_ref_stop_enable       <= ctrl2_reg[fcs_pkg::ERSTEN_BIT];
			ext_ref_oscillator_select <= ctrl2_reg[fcs_pkg::OSC_SEL_BIT];
			high_gain_select          <= ctrl2_reg[fcs_pkg::HIGH_GAIN_BIT];
			range_select              <= ctrl2_reg[fcs_pkg::RANGE_BIT];
			mode_state                <= mode_reg;
		end
	end

endmodule // fcs_clock_source

// ==== bench/fcs_ext_osc_model.sv ====
// External reference oscillator standing beside the clock source unit.
// Assumes the unit requests the oscillator through ext_ref_clock_enable.
`timescale 1ns/10ps

module fcs_ext_osc_model
#(
	parameter int PERIOD = 4
)
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic ext_ref_clock_enable,
	output logic      ext_ref_tick
);
	int cnt;

	// A stopped oscillator gives no edges, so a source that forgets the enable starves.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 0;
			ext_ref_tick <= 1'b0;
		end
		else if (ext_ref_clock_enable)
		begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			ext_ref_tick <= (cnt == PERIOD - 1);
		end
		else
		begin
			cnt <= 0;
			ext_ref_tick <= 1'b0;
		end
	end
endmodule // fcs_ext_osc_model

// ==== bench/fcs_clock_source_properties.sv ====
// Concurrent checks on the ports of the clock source unit.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps

module fcs_clock_source_properties
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        clock_source_output,
	input wire logic        bus_clock_en,
	input wire logic        background_debug_clock,
	input wire logic        fll_enabled,
	input wire logic        ext_ref_oscillator_select,
	input wire logic        high_gain_select,
	input wire logic        range_select,
	input wire logic [6:0]  mode_state
);
	logic [31:0] wdata_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Write data is released after the answer, so keep a copy for the check one cycle on.
	always_ff @(posedge clock)
	begin
		wdata_q <= pwdata;
	end

	chk_reset_mode: assert property ($fell(rst) |-> mode_state == 7'h01 && fll_enabled)
		else $error("mode after reset is not loop engaged internal");
	chk_mode_onehot: assert property ($onehot(mode_state))
		else $error("mode state is not one-hot");
	chk_bus_half: assert property (bus_clock_en |-> clock_source_output)
		else $error("bus clock without output clock");
	chk_stop_quiet: assert property (mode_state == 7'h40 && $past(mode_state) == 7'h40
		|-> !clock_source_output && !background_debug_clock)
		else $error("clock pulse in stop");
	chk_loop_off: assert property ((mode_state inside {7'h08, 7'h20, 7'h40})
		&& $stable(mode_state) |-> !fll_enabled)
		else $error("loop running in low power mode");
	chk_loop_on: assert property ((mode_state inside {7'h01, 7'h02, 7'h04, 7'h10})
		&& $stable(mode_state) |-> fll_enabled)
		else $error("loop stopped in loop mode");
	chk_dbg_loop: assert property (background_debug_clock
		|-> fll_enabled || $past(fll_enabled))
		else $error("debug clock without loop");
	chk_osc_copy: assert property (pready && pwrite && paddr == 12'h004
		|=> high_gain_select == wdata_q[4] && range_select == wdata_q[5]
		&& ext_ref_oscillator_select == wdata_q[2])
		else $error("oscillator controls differ from written value");
endmodule // fcs_clock_source_properties

bind fcs_clock_source fcs_clock_source_properties i_chk (.clock(clock), .rst(rst),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.clock_source_output(clock_source_output), .bus_clock_en(bus_clock_en),
	.background_debug_clock(background_debug_clock), .fll_enabled(fll_enabled),
	.ext_ref_oscillator_select(ext_ref_oscillator_select),
	.high_gain_select(high_gain_select), .range_select(range_select),
	.mode_state(mode_state));

// ==== bench/tb_fcs_clock_source.sv ====
// Self-checking bench for the clock source unit over APB.
// Assumes the external oscillator model answers every EXT_PER cycles when enabled.
`timescale 1ns/10ps

module tb_fcs_clock_source;
	localparam int          EXT_PER = 4;
	localparam logic [31:0] TRIM_V  = 32'h0000_0155;

	logic        clock   = 1'b0;
	logic        rst     = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic        stop_request = 1'b0;
	logic        bdm_active   = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, ext_ref_tick, clock_source_output, bus_clock_en;
	logic        background_debug_clock, fll_enabled, int_ref_clock_active;
	logic        ext_ref_clock_enable, ext_ref_stop_enable, ext_ref_oscillator_select;
	logic        high_gain_select, range_select;
	logic [6:0]  mode_state;
	int          err_total = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          n_cs = 0;
	int          n_bus = 0;
	int          n_dbg = 0;

	always #50 clock = ~clock;

	fcs_clock_source i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .stop_request(stop_request),
		.bdm_active(bdm_active), .ext_ref_tick(ext_ref_tick),
		.clock_source_output(clock_source_output), .bus_clock_en(bus_clock_en),
		.background_debug_clock(background_debug_clock), .fll_enabled(fll_enabled),
		.int_ref_clock_active(int_ref_clock_active),
		.ext_ref_clock_enable(ext_ref_clock_enable),
		.ext_ref_stop_enable(ext_ref_stop_enable),
		.ext_ref_oscillator_select(ext_ref_oscillator_select),
		.high_gain_select(high_gain_select), .range_select(range_select),
		.mode_state(mode_state));

	fcs_ext_osc_model #(.PERIOD(EXT_PER)) i_osc (.clock(clock), .rst(rst),
		.ext_ref_clock_enable(ext_ref_clock_enable), .ext_ref_tick(ext_ref_tick));

	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		n_cs <= n_cs + int'(clock_source_output === 1'b1);
		n_bus <= n_bus + int'(bus_clock_en === 1'b1);
		n_dbg <= n_dbg + int'(background_debug_clock === 1'b1);
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge clock);
			n++;
		end
		chk(32'(n < 20), 32'h0000_0001, "apb answer");
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		chk(32'(e), 32'h0000_0000, "write error");
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		chk(q, exp, "read data");
	endtask

	// Skips the first intervals, which may still span a divider change.
	task automatic period(output int p);
		int n;
		int t0;
		for (int k = 0; k < 4; k++)
		begin
			n = 0;
			t0 = cyc;
			@(posedge clock);
			while (clock_source_output !== 1'b1 && n < 3000)
			begin
				@(posedge clock);
				n++;
			end
			p = cyc - t0;
		end
	endtask

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] q;
		logic        e;
		chk(32'(mode_state), 32'h0000_0001, "reset mode");
		rd(fcs_pkg::CTRL1_ADDR, 32'h0000_0004);
		rd(fcs_pkg::CTRL2_ADDR, 32'h0000_0040);
		rd(fcs_pkg::TRIM_ADDR, 32'h0000_0100);
		apb(1'b0, 12'h010, 32'h0000_0000, q, e);
		chk(32'(e), 32'h0000_0001, "unmapped error");
		wr(fcs_pkg::TRIM_ADDR, 32'h0000_03FF);
		rd(fcs_pkg::TRIM_ADDR, 32'h0000_01FF);
		wr(fcs_pkg::TRIM_ADDR, TRIM_V);
		$display("reset test done");
	endtask

	task automatic t_bus_divider_select;
		int p;
		int nc;
		int nb;
		wr(fcs_pkg::CTRL1_ADDR, 32'h0000_0080);
		for (int b = 0; b < 4; b++)
		begin
			wr(fcs_pkg::CTRL2_ADDR, 32'(b << 6) | 32'h0000_0002);
			period(p);
			chk(32'(p), 32'(EXT_PER << b), "bus divider period");
			nc = n_cs;
			nb = n_bus;
			repeat (512) @(posedge clock);
			chk(32'((n_cs - nc - 2 * (n_bus - nb)) inside {-1, 0, 1}), 32'h0000_0001,
				"bus half");
		end
		$display("divider test done");
	endtask

	task automatic mode_row(input logic [7:0] c1, input logic low_pwr, input logic bdm,
		input logic [6:0] m, input logic loop);
		int nc;
		int nd;
		int p;
		wr(fcs_pkg::CTRL2_ADDR, low_pwr ? 32'h0000_000A : 32'h0000_0002);
		bdm_active <= bdm;
		wr(fcs_pkg::CTRL1_ADDR, {24'h00_0000, c1});
		repeat (8) @(posedge clock);
		chk(32'(mode_state), 32'(m), "mode");
		chk(32'(fll_enabled), 32'(loop), "loop enable");
		nc = n_cs;
		nd = n_dbg;
		repeat (700) @(posedge clock);
		chk(32'(n_cs > nc), 32'h0000_0001, "output clock");
		chk(32'(n_dbg > nd), 32'(loop), "debug clock");
		if (c1[7:6] == fcs_pkg::SRC_INT || c1[7:6] == fcs_pkg::SRC_EXT)
		begin
			period(p);
			chk(32'(p), (c1[7:6] == fcs_pkg::SRC_INT) ?
				32'(fcs_pkg::INT_REF_BASE) + TRIM_V + 1 : EXT_PER, "source period");
		end
	endtask

	task automatic t_modes;
		mode_row(8'h04, 1'b0, 1'b0, 7'h01, 1'b1);
		mode_row(8'h18, 1'b0, 1'b0, 7'h02, 1'b1);
		mode_row(8'h44, 1'b0, 1'b0, 7'h04, 1'b1);
		mode_row(8'h44, 1'b1, 1'b0, 7'h08, 1'b0);
		mode_row(8'h80, 1'b0, 1'b0, 7'h10, 1'b1);
		mode_row(8'h80, 1'b1, 1'b0, 7'h20, 1'b0);
		mode_row(8'h44, 1'b1, 1'b1, 7'h04, 1'b1);
		mode_row(8'hC4, 1'b0, 1'b0, 7'h01, 1'b1);
		rd(fcs_pkg::CTRL1_ADDR, 32'h0000_0004);
		$display("mode test done");
	endtask

	task automatic t_stop;
		int nc;
		int nd;
		wr(fcs_pkg::CTRL1_ADDR, 32'h0000_0006);
		repeat (4) @(posedge clock);
		chk({30'h0000_0000, int_ref_clock_active, ext_ref_clock_enable},
			32'h0000_0003, "refs run");
		stop_request <= 1'b1;
		repeat (10) @(posedge clock);
		chk(32'(mode_state), 32'h0000_0040, "stop mode");
		chk(32'(fll_enabled), 32'h0000_0000, "stop loop");
		chk({30'h0000_0000, int_ref_clock_active, ext_ref_clock_enable},
			32'h0000_0000, "refs stop");
		nc = n_cs;
		nd = n_dbg;
		repeat (500) @(posedge clock);
		chk(32'(n_cs - nc + n_dbg - nd), 32'h0000_0000, "stop pulses");
		stop_request <= 1'b0;
		repeat (10) @(posedge clock);
		chk(32'(mode_state), 32'h0000_0001, "leave stop");
		$display("stop test done");
	endtask

	task automatic t_osc;
		wr(fcs_pkg::CTRL2_ADDR, 32'h0000_0037);
		repeat (4) @(posedge clock);
		chk({27'h000_0000, range_select, high_gain_select, ext_ref_oscillator_select,
			ext_ref_clock_enable, ext_ref_stop_enable}, 32'h0000_001F, "osc on");
		wr(fcs_pkg::CTRL2_ADDR, 32'h0000_0040);
		repeat (4) @(posedge clock);
		chk({27'h000_0000, range_select, high_gain_select, ext_ref_oscillator_select,
			ext_ref_clock_enable, ext_ref_stop_enable}, 32'h0000_0000, "osc off");
		$display("oscillator test done");
	endtask

	initial
	begin
		#(100 * 60000);
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial
	begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_reset();
		t_bus_divider_select();
		t_modes();
		t_stop();
		t_osc();
		report_and_stop();
	end
endmodule // tb_fcs_clock_source
